// ### vtb_defines.vh
// Purpose: constants for the video timing and bitmap pixel block
// Assumes: one dot clock, counts as printed
// Notes: register offsets are byte addresses on the AXI4-Lite slave
`ifndef VTB_DEFINES_VH
`define VTB_DEFINES_VH
`define VTB_H_LAST 9'd455
`define VTB_HS_ON 9'd358
`define VTB_HS_OFF 9'd390
`define VTB_EQ1_ON 9'd152
`define VTB_EQ1_OFF 9'd170
`define VTB_EQ2_ON 9'd380
`define VTB_EQ2_OFF 9'd398
`define VTB_HB_ON 9'd344
`define VTB_HB_OFF 9'd416
`define VTB_BU_ON 9'd384
`define VTB_BU_OFF 9'd408
`define VTB_CW_ON 9'd432
`define VTB_CW_OFF 9'd296
`define VTB_XF_ON 9'd400
`define VTB_XF_OFF 9'd288
`define VTB_RS_ON 9'd288
`define VTB_RS_OFF 9'd328
`define VTB_S40_ON 9'd451
`define VTB_S40_OFF 9'd315
`define VTB_S38_ON 9'd3
`define VTB_S38_OFF 9'd307
`define VTB_SH_ON 9'd440
`define VTB_SH_OFF 9'd304
`define VTB_BLINK_H 9'd336
`define VTB_RF_ON 9'd296
`define VTB_RF_OFF 9'd336
`define VTB_CPR_H 9'd424
`define VTB_CP_ON 9'd432
`define VTB_CP_OFF 9'd288
`define VTB_CPL_H 9'd290
`define VTB_VINC_H 9'd376
`define VTB_EOS_H 9'd384
`define VTB_SC_ON 9'd400
`define VTB_SC_OFF 9'd344
`define VTB_RFC_ON 9'd304
`define VTB_RFC_OFF 9'd344
`define VTB_V_END_PAL 9'd311
`define VTB_V_END_NTSC 9'd261
`define VTB_VS_PAL_ON 9'd254
`define VTB_VS_PAL_OFF 9'd257
`define VTB_VS_NTSC_ON 9'd229
`define VTB_VS_NTSC_OFF 9'd232
`define VTB_VE_PAL_ON 9'd251
`define VTB_VE_PAL_OFF 9'd260
`define VTB_VE_NTSC_ON 9'd226
`define VTB_VE_NTSC_OFF 9'd235
`define VTB_ATTR_LAST 9'd203
`define VTB_FRAME_STOP 9'd204
`define VTB_VSCR_ON 9'd4
`define VTB_CP_LAST 10'd999
`define VTB_REFRESH_N 3'd5
`define VTB_BLINK_FRAMES 8'd25
// register byte offsets
`define VTB_R_MODE 8'h00
`define VTB_R_BASE 8'h04
`define VTB_R_CURSOR 8'h08
`define VTB_R_BKG 8'h0c
`define VTB_R_STATUS 8'h10
`define VTB_R_REFRESH 8'h14
// mode register fields
`define VTB_M_MULTI 0
`define VTB_M_FLASH 1
`define VTB_M_ECM 6
`define VTB_M_BITMAP 5
`define VTB_M_ENABLE 4
`define VTB_M_NTSC 7
`define VTB_M_COL40 8
`define VTB_MODE_RST 32'h00000090
`endif

// ### vtb_video_timing.v
// Purpose: dot/line counters, timing decodes, bitmap fetch and pixels
// Assumes: one dot clock; memory data valid in the same cycle as its address
// Notes: registers over an AXI4-Lite slave; no sound logic
`include "vtb_defines.vh"
module vtb_video_timing #(
  parameter BLINK_FRAMES = 8'd25
) (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] mem_addr,
  output reg mem_fetch,
  output reg mem_ras_only,
  input wire [7:0] mem_data,
  input wire [7:0] matrix_data,
  input wire [7:0] attr_data,
  output reg [3:0] pix_color,
  output reg [2:0] pix_lum,
  output reg hsync,
  output reg vsync,
  output reg hblank,
  output reg burst,
  output reg equalize,
  output reg cpu_single_clk
);
  reg [31:0] mode_reg;
  reg [2:0] bitmap_base;
  reg [9:0] cursor_reg;
  reg [31:0] bkg_reg;
  reg [8:0] h_reg;
  reg [8:0] v_reg;
  reg [9:0] char_position_count;
  reg [9:0] cp_reload_reg;
  reg [2:0] row_within_cell;
  reg [7:0] refresh_row_reg;
  reg [7:0] blink_cnt_reg;
  reg blink_reg;
  reg [7:0] shift_reg;
  reg [7:0] mtx_reg;
  reg [7:0] attr_reg;
  reg [2:0] dot_reg;
  reg cursor_hit_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire enable = mode_reg[`VTB_M_ENABLE];
  wire bitmap = mode_reg[`VTB_M_BITMAP];
  wire multi = mode_reg[`VTB_M_MULTI];
  wire ntsc = mode_reg[`VTB_M_NTSC];
  wire mc_bitmap = multi & bitmap;
  wire std_char = ~bitmap & ~multi & ~mode_reg[`VTB_M_ECM];
  wire [8:0] v_end = ntsc ? `VTB_V_END_NTSC : `VTB_V_END_PAL;
  // window test across the line wrap
  function win;
    input [8:0] h;
    input [8:0] on;
    input [8:0] off;
    begin
      if (on <= off)
        win = (h >= on) && (h < off);
      else
        win = (h >= on) || (h < off);
    end
  endfunction
  wire char_win = win(h_reg, `VTB_CW_ON, `VTB_CW_OFF);
  wire xfetch_win = win(h_reg, `VTB_XF_ON, `VTB_XF_OFF);
  wire rsingle_win = win(h_reg, `VTB_RS_ON, `VTB_RS_OFF);
  wire shift_win = win(h_reg, `VTB_SH_ON, `VTB_SH_OFF);
  wire cp_step_win = win(h_reg, `VTB_CP_ON, `VTB_CP_OFF);
  wire refresh_win = win(h_reg, `VTB_RF_ON, `VTB_RF_OFF);
  wire scr40 = win(h_reg, `VTB_S40_ON, `VTB_S40_OFF);
  wire scr38 = win(h_reg, `VTB_S38_ON, `VTB_S38_OFF);
  wire attr_line = (v_reg <= `VTB_ATTR_LAST);
  wire frame_win = (v_reg < `VTB_FRAME_STOP);
  wire vscreen = (v_reg >= `VTB_VSCR_ON) && attr_line;
  // dot fetches follow the character window; the processor window is
  // only reported in the status word
  wire fetch_on = enable && attr_line && vscreen;
  wire h_screen = mode_reg[`VTB_M_COL40] ? scr40 : scr38;
  wire shown = enable && vscreen && h_screen;
  wire rf_single = win(h_reg, `VTB_RFC_ON, `VTB_RFC_OFF);
  // refresh slots: 8 dots apart, five of them after character fetches
  wire rf_slot = refresh_win && (h_reg[2:0] == 3'd0);
  // cursor swaps the two colours, flash turns the foreground off
  wire cur_swap = std_char && cursor_hit_reg && blink_reg;
  wire flash_off = std_char && mode_reg[`VTB_M_FLASH] && attr_reg[7] &&
                   blink_reg;
  // dot and line counters
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      h_reg <= 9'd0;
      v_reg <= 9'd0;
    end else begin
      if (h_reg == `VTB_H_LAST)
        h_reg <= 9'd0;
      else
        h_reg <= h_reg + 9'd1;
      if (h_reg == `VTB_VINC_H) begin
        if (v_reg == v_end)
          v_reg <= 9'd0;
        else
          v_reg <= v_reg + 9'd1;
      end
    end
  end
  // sync, blanking and processor clock decodes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hsync <= 1'b0;
      hblank <= 1'b1;
      burst <= 1'b0;
      equalize <= 1'b0;
      vsync <= 1'b0;
      cpu_single_clk <= 1'b0;
    end else begin
      hsync <= win(h_reg, `VTB_HS_ON, `VTB_HS_OFF);
      hblank <= win(h_reg, `VTB_HB_ON, `VTB_HB_OFF);
      burst <= win(h_reg, `VTB_BU_ON, `VTB_BU_OFF);
      equalize <= (win(h_reg, `VTB_EQ1_ON, `VTB_EQ1_OFF) ||
                   win(h_reg, `VTB_EQ2_ON, `VTB_EQ2_OFF)) &&
                  (ntsc ? win(v_reg, `VTB_VE_NTSC_ON, `VTB_VE_NTSC_OFF)
                        : win(v_reg, `VTB_VE_PAL_ON, `VTB_VE_PAL_OFF));
      vsync <= ntsc ? win(v_reg, `VTB_VS_NTSC_ON, `VTB_VS_NTSC_OFF)
                    : win(v_reg, `VTB_VS_PAL_ON, `VTB_VS_PAL_OFF);
      if (enable && (v_reg <= `VTB_FRAME_STOP))
        cpu_single_clk <= win(h_reg, `VTB_SC_ON, `VTB_SC_OFF);
      else
        cpu_single_clk <= rf_single;
    end
  end
  // character position, row counter, refresh and blink
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      char_position_count <= 10'd0;
      cp_reload_reg <= 10'd0;
      row_within_cell <= 3'd0;
      refresh_row_reg <= 8'd0;
      blink_cnt_reg <= 8'd0;
      blink_reg <= 1'b0;
    end else begin
      if (h_reg == `VTB_EOS_H && v_reg == v_end) begin
        cp_reload_reg <= 10'd0;
        row_within_cell <= 3'd0;
      end else if (h_reg == `VTB_CPL_H && vscreen) begin
        if (row_within_cell == 3'd7)
          cp_reload_reg <= char_position_count;
        row_within_cell <= row_within_cell + 3'd1;
      end
      // the step at the stop count makes the 290 latch hold the next row
      if (h_reg == `VTB_CPR_H)
        char_position_count <= cp_reload_reg;
      else if ((cp_step_win || h_reg == `VTB_CP_OFF) && vscreen &&
               h_reg[2:0] == 3'd0)
        char_position_count <= char_position_count + 10'd1;
      if (rf_slot)
        refresh_row_reg <= refresh_row_reg + 8'd1;
      if (h_reg == `VTB_BLINK_H && v_reg == 9'd0) begin
        if (blink_cnt_reg == BLINK_FRAMES - 8'd1) begin
          blink_cnt_reg <= 8'd0;
          blink_reg <= ~blink_reg;
        end else
          blink_cnt_reg <= blink_cnt_reg + 8'd1;
      end
    end
  end
  // memory address: bitmap dots or RAS-only refresh rows
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_addr <= 16'h0000;
      mem_fetch <= 1'b0;
      mem_ras_only <= 1'b0;
    end else begin
      mem_fetch <= fetch_on && char_win && h_reg[2:0] == 3'd0;
      mem_ras_only <= rf_slot;
      if (rf_slot)
        mem_addr <= {8'h00, refresh_row_reg};
      else
        mem_addr <= {bitmap_base, char_position_count,
                     row_within_cell};
    end
  end
  // dot shifter and per-cell colour latches
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 8'h00;
      mtx_reg <= 8'h00;
      attr_reg <= 8'h00;
      dot_reg <= 3'd0;
      cursor_hit_reg <= 1'b0;
    end else begin
      if (mem_fetch) begin
        shift_reg <= mem_data;
        mtx_reg <= matrix_data;
        attr_reg <= attr_data;
        dot_reg <= 3'd0;
        // compare the cell being loaded, not the count that moved on
        cursor_hit_reg <= (mem_addr[12:3] == cursor_reg) &&
                          (cursor_reg <= `VTB_CP_LAST);
      end else if (shift_win) begin
        dot_reg <= dot_reg + 3'd1;
        if (!mc_bitmap)
          shift_reg <= {shift_reg[6:0], 1'b0};
        else if (dot_reg[0])
          shift_reg <= {shift_reg[5:0], 2'b00};
      end
    end
  end
  // colour and luminance selection
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pix_color <= 4'h0;
      pix_lum <= 3'd0;
    end else if (!shown) begin
      pix_color <= bkg_reg[27:24]; // border colour
      pix_lum <= bkg_reg[30:28];
    end else if (mc_bitmap) begin
      case (shift_reg[7:6])
        2'b00: begin
          pix_color <= bkg_reg[3:0];
          pix_lum <= bkg_reg[6:4];
        end
        2'b01: begin
          pix_color <= mtx_reg[7:4];
          pix_lum <= attr_reg[6:4];
        end
        2'b10: begin
          pix_color <= mtx_reg[3:0];
          pix_lum <= attr_reg[6:4];
        end
        default: begin
          pix_color <= bkg_reg[11:8];
          pix_lum <= bkg_reg[14:12];
        end
      endcase
    end else if (bitmap) begin
      if (shift_reg[7]) begin
        pix_color <= mtx_reg[7:4];
        pix_lum <= attr_reg[2:0];
      end else begin
        pix_color <= mtx_reg[3:0];
        pix_lum <= attr_reg[6:4];
      end
    end else begin
      // standard character: cursor swap and flash
      if ((shift_reg[7] ^ cur_swap) && !flash_off) begin
        pix_color <= attr_reg[3:0];
        pix_lum <= attr_reg[6:4];
      end else begin
        pix_color <= bkg_reg[3:0];
        pix_lum <= bkg_reg[6:4];
      end
    end
  end
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
  wire aw_ok = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
  wire w_ok = w_hold_reg | (s_axi_wvalid & s_axi_wready);
  wire [7:0] wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_go = aw_ok & w_ok & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire wr_hit = (wa == `VTB_R_MODE) || (wa == `VTB_R_BASE) ||
                (wa == `VTB_R_CURSOR) || (wa == `VTB_R_BKG);
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      mode_reg <= `VTB_MODE_RST;
      bitmap_base <= 3'd0;
      cursor_reg <= 10'h3ff;
      bkg_reg <= 32'h00000000;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
        case (wa)
          `VTB_R_MODE: mode_reg <= (mode_reg & ~wmask) | (wd & wmask);
          `VTB_R_BASE: begin
            if (ws[0])
              bitmap_base <= wd[5:3];
          end
          `VTB_R_CURSOR: begin
            if (ws[0])
              cursor_reg[7:0] <= wd[7:0];
            if (ws[1])
              cursor_reg[9:8] <= wd[9:8];
          end
          `VTB_R_BKG: bkg_reg <= (bkg_reg & ~wmask) | (wd & wmask);
          default: begin
          end
        endcase
      end else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // AXI4-Lite read path, one cycle answer
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `VTB_R_MODE: s_axi_rdata <= mode_reg;
        `VTB_R_BASE: s_axi_rdata <= {26'd0, bitmap_base, 3'd0};
        `VTB_R_CURSOR: s_axi_rdata <= {22'd0, cursor_reg};
        `VTB_R_BKG: s_axi_rdata <= bkg_reg;
        `VTB_R_STATUS: s_axi_rdata <= {7'd0, blink_reg, frame_win,
                                       h_reg, 3'd0, xfetch_win,
                                       rsingle_win, v_reg};
        `VTB_R_REFRESH: s_axi_rdata <= {14'd0, cp_reload_reg,
                                        refresh_row_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// ### vtb_checker_assertions.sv
// Purpose: port-level checks of line timing and dram refresh
// Assumes: decoded outputs land one cycle after their count
// Notes: timings are taken relative to each other; no count is mirrored
module vtb_checker #(
  parameter BLINK_FRAMES = 8'd25
) (
  input wire sys_clk,
  input wire resetn,
  input wire [15:0] mem_addr,
  input wire mem_fetch,
  input wire mem_ras_only,
  input wire hsync,
  input wire hblank,
  input wire burst,
  input wire cpu_single_clk
);
  reg hs_q;
  reg hb_q;
  reg seen;
  reg [8:0] lcnt;
  reg [2:0] rcnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // cycles since the last hsync rise, refresh pulses since hblank rise
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hs_q <= 1'b0;
      hb_q <= 1'b1;
      seen <= 1'b0;
      lcnt <= 9'h000;
      rcnt <= 3'h0;
    end else begin
      hs_q <= hsync;
      hb_q <= hblank;
      lcnt <= (hsync && !hs_q) ? 9'h000 : lcnt + 9'h001;
      if (hsync && !hs_q) seen <= 1'b1;
      rcnt <= (hblank && !hb_q) ? 3'h0 : rcnt + {2'b00, mem_ras_only};
    end
  end
  property p_line_len; $rose(hsync) && seen |-> lcnt == 9'd455; endproperty
  a_line_len: assert property (p_line_len)
    else $error("line length is not 456 dots");
  property p_hs_width; $rose(hsync) |-> ##31 hsync ##1 !hsync; endproperty
  a_hs_width: assert property (p_hs_width)
    else $error("hsync width wrong");
  property p_hb_hs; $rose(hblank) |-> ##14 $rose(hsync); endproperty
  a_hb_hs: assert property (p_hb_hs)
    else $error("hsync start not 14 after hblank");
  property p_hb_width; $rose(hblank) |-> ##72 $fell(hblank); endproperty
  a_hb_width: assert property (p_hb_width)
    else $error("hblank width wrong");
  property p_burst;
    $rose(hsync) |-> ##26 $rose(burst) ##24 $fell(burst);
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst window wrong");
  property p_sc_drop; $rose(hblank) |-> $fell(cpu_single_clk); endproperty
  a_sc_drop: assert property (p_sc_drop)
    else $error("single clock not ending at blank start");
  property p_ras_gap; mem_ras_only |=> !mem_ras_only [*7]; endproperty
  a_ras_gap: assert property (p_ras_gap)
    else $error("refresh pulses closer than 8");
  property p_ras_cnt;
    $rose(hblank) |-> rcnt == 3'd5 && $past(mem_ras_only, 16);
  endproperty
  a_ras_cnt: assert property (p_ras_cnt)
    else $error("not five refreshes before blank");
  property p_ras_addr;
    mem_ras_only |-> mem_addr[15:8] == 8'h00 && !mem_fetch;
  endproperty
  a_ras_addr: assert property (p_ras_addr)
    else $error("refresh address or fetch overlap wrong");
  property p_ras_row;
    mem_ras_only ##8 mem_ras_only |->
      mem_addr[7:0] == $past(mem_addr[7:0], 8) + 8'h01;
  endproperty
  a_ras_row: assert property (p_ras_row)
    else $error("refresh row did not step by one");
  c_hsync: cover property ($rose(hsync));
  c_fetch: cover property (mem_fetch);
  c_sc: cover property ($rose(cpu_single_clk));
endmodule
bind vtb_video_timing vtb_checker #(.BLINK_FRAMES(BLINK_FRAMES)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .mem_addr(mem_addr),
  .mem_fetch(mem_fetch), .mem_ras_only(mem_ras_only), .hsync(hsync),
  .hblank(hblank), .burst(burst), .cpu_single_clk(cpu_single_clk));

// ### vtb_mem_model.sv
// Purpose: shared dram and colour memory seen by the fetch port
// Assumes: data is taken on the edge where mem_fetch is high
// Notes: outside fetches the bus churns so stale values never match
module vtb_mem_model (
  input wire sys_clk,
  input wire mem_fetch,
  input wire [7:0] dot_byte,
  input wire [7:0] mat_byte,
  input wire [7:0] att_byte,
  output logic [7:0] mem_data,
  output logic [7:0] matrix_data,
  output logic [7:0] attr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk = 8'h00;
  // undriven bus pattern changes every cycle
  always @(posedge sys_clk) junk <= junk + 8'h3b;
  // fetched bytes only while a fetch is on the bus
  assign mem_data = mem_fetch ? dot_byte : junk;
  assign matrix_data = mem_fetch ? mat_byte : ~junk;
  assign attr_data = mem_fetch ? att_byte : junk ^ 8'h5a;
endmodule

// ### tb_top.sv
// Purpose: register, fetch, clock and pixel tests of the video block
// Assumes: 100 MHz dot clock, design answers on AXI4-Lite
// Notes: blink period shortened; tests end before line 204
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mem_addr;
  logic mem_fetch, mem_ras_only, hsync, vsync, hblank, burst, equalize;
  logic cpu_single_clk;
  logic [7:0] mem_data, matrix_data, attr_data;
  logic [7:0] dot_byte = 8'h00, mat_byte = 8'h5a, att_byte = 8'h31;
  logic [3:0] pix_color;
  logic [2:0] pix_lum;
  integer error_cnt = 0, checks_done = 0, cyc = 0, i;
  logic [31:0] d, n, f;
  logic [1:0] r;
  logic [15:0] a0, a1;
  logic [6:0] px;
  logic [31:0] t_mode [0:9] = '{32'hb0, 32'hb0, 32'hb1, 32'hb1, 32'hb1,
                                32'hb1, 32'h1b0, 32'h30, 32'h92, 32'h92};
  logic [7:0] t_dot [0:9] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'h55, 8'haa,
                              8'hff, 8'h00, 8'hff, 8'hff};
  logic [7:0] t_att [0:9] = '{8'h31, 8'h31, 8'h31, 8'h31, 8'h31, 8'h31,
                              8'h31, 8'h31, 8'h31, 8'hb1};
  logic [6:0] t_px [0:9] = '{7'h15, 7'h3a, 7'h26, 7'h7c, 7'h35, 7'h3a,
                             7'h15, 7'h3a, 7'h31, 7'h26};
  vtb_video_timing #(.BLINK_FRAMES(8'd1)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_addr(mem_addr), .mem_fetch(mem_fetch),
    .mem_ras_only(mem_ras_only), .mem_data(mem_data),
    .matrix_data(matrix_data), .attr_data(attr_data), .pix_color(pix_color),
    .pix_lum(pix_lum), .hsync(hsync), .vsync(vsync), .hblank(hblank),
    .burst(burst), .equalize(equalize), .cpu_single_clk(cpu_single_clk));
  vtb_mem_model u_mem (
    .sys_clk(sys_clk), .mem_fetch(mem_fetch), .dot_byte(dot_byte),
    .mat_byte(mat_byte), .att_byte(att_byte), .mem_data(mem_data),
    .matrix_data(matrix_data), .attr_data(attr_data));
  // dot clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] v, output [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task axi_rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // pixel well inside the screen, two lines after any change
  task line_pix(output [6:0] p);
    repeat (2) begin
      while (hblank !== 1'b1) @(posedge sys_clk);
      while (hblank !== 1'b0) @(posedge sys_clk);
    end
    repeat (200) @(posedge sys_clk);
    p = {pix_lum, pix_color};
  endtask
  // single clock and fetch cycles over one whole line
  task sc_count(output [31:0] sc, output [31:0] fc);
    sc = 0;
    fc = 0;
    repeat (456) begin
      @(posedge sys_clk);
      if (cpu_single_clk === 1'b1) sc = sc + 1;
      if (mem_fetch === 1'b1) fc = fc + 1;
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    axi_rd(8'h00, d, r);
    chk(d, 32'h00000090);
    axi_rd(8'h20, d, r);
    chk(32'(r), 32'h2);
    axi_wr(8'h24, 32'h1, r);
    chk(32'(r), 32'h2);
    sc_count(n, f);
    chk(n, 32'd400);
    axi_wr(8'h0c, 32'h4b007c26, r);
    axi_wr(8'h00, 32'h80, r);
    sc_count(n, f);
    sc_count(n, f);
    chk(n, 32'd40);
    chk(f, 32'd0);
    line_pix(px);
    chk(32'(px), 32'h4b);
    axi_wr(8'h04, 32'h28, r);
    axi_wr(8'h00, 32'hb0, r);
    line_pix(px);
    while (mem_fetch !== 1'b1) @(posedge sys_clk);
    a0 = mem_addr;
    @(posedge sys_clk);
    while (mem_fetch !== 1'b1) @(posedge sys_clk);
    a1 = mem_addr;
    chk(32'(a0[15:13]), 32'h5);
    chk(32'(a1[12:3]), 32'(a0[12:3] + 10'h001));
    chk(32'(a1[2:0]), 32'(a0[2:0]));
    sc_count(n, f);
    chk(f, 32'd40);
    chk(n, 32'd400);
    for (i = 0; i < 10; i = i + 1) begin
      axi_wr(8'h00, t_mode[i], r);
      dot_byte <= t_dot[i];
      att_byte <= t_att[i];
      line_pix(px);
      chk(32'(px), 32'(t_px[i]));
    end
    // cursor on the cell shown at the sample point two lines ahead
    att_byte <= 8'h31;
    while (hblank !== 1'b1) @(posedge sys_clk);
    while (hblank !== 1'b0) @(posedge sys_clk);
    axi_rd(8'h10, d, r);
    chk(32'(d[24]), 32'h1);
    n = 40 * ((d[8:0] - 32'd2) / 8) + 22;
    axi_wr(8'h08, n, r);
    line_pix(px);
    chk(32'(px), 32'h26);
    chk(32'(vsync | equalize), 32'h0);
    test_done();
  end
endmodule
